// *** testbench/bsc_ctrl_asserts.sv ***
// Purpose: port-level checks of the security-state controller
// Assumes: one clock, rst_n async active low
// Notes: only the ports needed by the checks are watched
`timescale 1ns/1ps
module bsc_ctrl_asserts (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire cmd_select,
    input wire cmd_chan_open,
    input wire cmd_verify,
    input wire cmd_sec_error,
    input wire cmp_done,
    input wire [1:0] sec_state_ff,
    input wire cmp_start_ff,
    input wire verify_ok_ff,
    input wire verify_fail_ff,
    input wire verify_refused_ff,
    input wire app_blocked_ff,
    input wire ws_busy_ff,
    input wire ws_abort_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Channel from idle, with no select, error, comparison end or busy work-sharing at the same edge
    AST_CHAN: assert property (ce && cmd_chan_open && sec_state_ff == 2'h0 && !cmd_select
        && !cmd_sec_error && !cmp_done && !ws_busy_ff |=> sec_state_ff == 2'h1)
        else $error("channel open did not reach state 1");
    AST_SEL: assert property (ce && cmd_select |=> sec_state_ff == 2'h0)
        else $error("select kept a raised state");
    AST_ERR: assert property (ce && cmd_sec_error |=> sec_state_ff == 2'h0)
        else $error("security error kept a raised state");
    AST_FAIL: assert property (verify_fail_ff |-> sec_state_ff == 2'h0 && !verify_ok_ff)
        else $error("failed verify left state raised");
    // A comparison only ever follows a verify taken in state 1
    AST_START: assert property (cmp_start_ff |-> $past(sec_state_ff) == 2'h1 && $past(cmd_verify))
        else $error("comparison started outside state 1");
    AST_REF: assert property (ce && cmd_verify && sec_state_ff != 2'h1 |=> verify_refused_ff && !cmp_start_ff)
        else $error("verify not refused without channel");
    AST_BLK: assert property (ce && cmd_verify && app_blocked_ff |=> verify_refused_ff && !cmp_start_ff)
        else $error("blocked application compared");
    AST_OK: assert property (verify_ok_ff |-> sec_state_ff == 2'h2 || sec_state_ff == 2'h3)
        else $error("grant without raised state");
    // Abort goes through the error path, so the state drops at the edge that raises ws_abort_ff
    AST_WS: assert property (ws_abort_ff |-> ##[0:2] sec_state_ff == 2'h0)
        else $error("session abort did not drop state");
endmodule
bind bsc_ctrl bsc_ctrl_asserts bsc_ctrl_asserts_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .cmd_select(cmd_select), .cmd_chan_open(cmd_chan_open), .cmd_verify(cmd_verify),
    .cmd_sec_error(cmd_sec_error), .cmp_done(cmp_done), .sec_state_ff(sec_state_ff),
    .cmp_start_ff(cmp_start_ff), .verify_ok_ff(verify_ok_ff), .verify_fail_ff(verify_fail_ff),
    .verify_refused_ff(verify_refused_ff), .app_blocked_ff(app_blocked_ff),
    .ws_busy_ff(ws_busy_ff), .ws_abort_ff(ws_abort_ff));

// *** testbench/bsc_ctrl_tb.sv ***
// Purpose: directed test of the security-state controller
// Assumes: ce held high, commands from the terminal model
// Notes: indices 0 select 1 chan 2 close 3 verify 4 err 5 ws 6 get 7 put 8 rej 9 done
`timescale 1ns/1ps
`define chk(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module bsc_ctrl_tb;
    logic clk, rst_n, ce, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    wire [31:0] reg_rdata_ff;
    wire [1:0] sec_state_ff;
    wire cmp_start_ff, verify_ok_ff, verify_fail_ff, verify_refused_ff;
    wire app_blocked_ff, ws_busy_ff, ws_abort_ff;
    wire [9:0] pulse;
    wire [7:0] arg;
    int n_fail = 0;
    int checks = 0;
    logic [31:0] rst_val [8] = '{32'h0, 32'h0, 32'h80, 32'hc0, 32'h3, 32'h3, 32'h0, 32'h0};
    bsc_ctrl bsc_ctrl_i (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .cmd_select(pulse[0]),
        .cmd_app(arg[1:0]), .cmd_chan_open(pulse[1]), .cmd_chan_close(pulse[2]),
        .cmd_verify(pulse[3]), .cmd_sec_error(pulse[4]), .cmp_ws_start(pulse[5]),
        .cmd_get_data(pulse[6]), .cmd_put_result(pulse[7]), .cmd_reject(pulse[8]),
        .cmp_done(pulse[9]), .cmp_score(arg), .reg_rdata_ff(reg_rdata_ff),
        .sec_state_ff(sec_state_ff), .cmp_start_ff(cmp_start_ff), .verify_ok_ff(verify_ok_ff),
        .verify_fail_ff(verify_fail_ff), .verify_refused_ff(verify_refused_ff),
        .app_blocked_ff(app_blocked_ff), .ws_busy_ff(ws_busy_ff), .ws_abort_ff(ws_abort_ff));
    bsc_term bsc_term_i (.clk(clk), .pulse(pulse), .arg(arg));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task print_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `chk("rdata", e, reg_rdata_ff)
    endtask
    // Full attempt: channel, verify, optional work-sharing, score, retry readback
    task att(input logic [7:0] s, input logic [1:0] es, input logic [31:0] er, input logic w);
        // Close first: open is only taken from state 0, so a raised state must drop
        bsc_term_i.send(2, 8'h0);
        bsc_term_i.open_verify();
        if (w) begin
            bsc_term_i.send(5, 8'h0);
            bsc_term_i.send(6, 8'h0);
            #1 `chk("ws_busy", 1'b1, ws_busy_ff)
            bsc_term_i.send(7, 8'h0);
        end
        bsc_term_i.send(9, s);
        #1 `chk("state", es, sec_state_ff)
        `chk("ok", es != 2'h0, verify_ok_ff)
        rd(4'h5, er);
    endtask
    // Hang guard, far beyond the roughly 150 cycles the tests need
    initial begin
        #(25 * 20000);
        n_fail++;
        print_verdict();
    end
    initial begin
        ce = 1'b1;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wr(4'h7, 32'hffff_ffff);
        for (int i = 0; i < 8; i++) rd(i[3:0], rst_val[i]);
        `chk("state", 2'h0, sec_state_ff)
        bsc_term_i.send(3, 8'h0);
        #1 `chk("refused", 1'b1, verify_refused_ff)
        att(8'h80, 2'h0, 32'h2, 1'b0);
        att(8'h81, 2'h2, 32'h3, 1'b0);
        wr(4'h0, 32'h1);
        att(8'h80, 2'h0, 32'h2, 1'b0);
        att(8'hc0, 2'h2, 32'h3, 1'b1);
        att(8'hc1, 2'h3, 32'h3, 1'b0);
        bsc_term_i.send(0, 8'h1);
        #1 `chk("state", 2'h0, sec_state_ff)
        wr(4'h2, 32'h10);
        for (int i = 2; i >= 0; i--) att(8'h10, 2'h0, i, 1'b0);
        `chk("blocked", 1'b1, app_blocked_ff)
        bsc_term_i.open_verify();
        #1 `chk("refused", 1'b1, verify_refused_ff)
        bsc_term_i.send(4, 8'h0);
        #1 `chk("state", 2'h0, sec_state_ff)
        bsc_term_i.send(0, 8'h0);
        rd(4'h2, 32'h80);
        rd(4'h5, 32'h3);
        bsc_term_i.send(1, 8'h0);
        #1 `chk("state", 2'h1, sec_state_ff)
        bsc_term_i.send(3, 8'h0);
        bsc_term_i.send(5, 8'h0);
        bsc_term_i.send(8, 8'h0);
        repeat (3) @(posedge clk);
        #1 `chk("state", 2'h0, sec_state_ff)
        `chk("ws_busy", 1'b0, ws_busy_ff)
        print_verdict();
    end
endmodule

// *** testbench/bsc_term.sv ***
// Purpose: terminal model issuing one-cycle card commands
// Assumes: a free cycle between commands
// Notes: argument turns to junk once its command is gone
`timescale 1ns/1ps
module bsc_term (
    input wire clk,
    output logic [9:0] pulse,
    output logic [7:0] arg
);
    initial begin
        pulse = 10'h0;
        arg = 8'h0;
    end
    // One command pulse; argument inverted afterwards so nothing stale helps
    task send(input int k, input logic [7:0] v);
        @(posedge clk);
        pulse <= 10'h1 << k;
        arg <= v;
        @(posedge clk);
        pulse <= 10'h0;
        arg <= ~v;
    endtask
    // Channel first, then verify
    task open_verify();
        send(1, 8'h0);
        send(3, 8'h0);
    endtask
endmodule

// *** verilog/bsc_ctrl.v ***
// Purpose: security-state controller for on-card biometric comparison
// Assumes: card commands arrive as one-cycle pulses on the card clock
// Notes: cryptography, matching algorithm and command framing live elsewhere
//
// Notes on behaviour
// - State 0 initial; higher means more privilege
// - Single threshold: grant only if score exceeds
// - No comparison without an active secure channel; a close mid-comparison does not abort it, and a pass still raises the state
// - Secure channel moves state 0 to 1
// - Single threshold grant raises state one step
// - Failed verify reports error, returns to 0
// - Failure decrements retries by one; zero blocks
// - Two thresholds: at or below lower denies
// - Between thresholds grants level 1 only
// - Above upper threshold grants level 2
// - Any security error returns to state 0
// - Per-application thresholds and retry counters
// - Application select resets security state
// - Failure decrements only selected application's counter
// - Counter at zero blocks that application
// - Success restores the selected application's counter
// - Broken work-sharing sequence returns to ready
// - Comparison pauses for work-sharing result
`timescale 1ns/1ps
`include "bsc_regs.vh"
module bsc_ctrl #(
    parameter NUM_APPS = 4,
    parameter APP_W = 2,
    parameter SCORE_W = 8,
    parameter RETRY_W = 4
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire cmd_select,
    input wire [APP_W-1:0] cmd_app,
    input wire cmd_chan_open,
    input wire cmd_chan_close,
    input wire cmd_verify,
    input wire cmd_sec_error,
    input wire cmp_ws_start,
    input wire cmd_get_data,
    input wire cmd_put_result,
    input wire cmd_reject,
    input wire cmp_done,
    input wire [SCORE_W-1:0] cmp_score,
    output reg [31:0] reg_rdata_ff,
    output reg [1:0] sec_state_ff,
    output reg cmp_start_ff,
    output reg verify_ok_ff,
    output reg verify_fail_ff,
    output reg verify_refused_ff,
    output reg app_blocked_ff,
    output reg ws_busy_ff,
    output reg ws_abort_ff
);
    localparam V_IDLE = 2'd0;
    localparam V_CMP = 2'd1;
    localparam V_WS = 2'd2;

    reg two_th_ff;
    reg chan_ff;
    reg [APP_W-1:0] app_ff;
    reg [1:0] vst_ff;
    reg [1:0] nxt_vst;
    reg [SCORE_W-1:0] last_score_ff;
    reg [SCORE_W-1:0] lower_th_ff [0:NUM_APPS-1];
    reg [SCORE_W-1:0] upper_th_ff [0:NUM_APPS-1];
    reg [RETRY_W-1:0] retry_init_ff [0:NUM_APPS-1];
    reg [RETRY_W-1:0] retry_ff [0:NUM_APPS-1];
    wire ws_busy_w;
    wire ws_waiting_w;
    wire ws_done_w;
    wire ws_abort_w;
    wire [SCORE_W-1:0] cur_lower;
    wire [SCORE_W-1:0] cur_upper;
    wire cur_blocked;
    wire pass_lower;
    wire pass_upper;
    wire grant;
    wire fail;
    wire sec_err;
    wire verify_go;
    wire verify_refuse;
    wire foreign_cmd;

    assign cur_lower = lower_th_ff[app_ff];
    assign cur_upper = upper_th_ff[app_ff];
    assign cur_blocked = (retry_ff[app_ff] == {RETRY_W{1'b0}});
    // Strict comparisons: an equal score is a miss
    assign pass_lower = (cmp_score > cur_lower);
    assign pass_upper = (cmp_score > cur_upper);
    assign grant = (vst_ff == V_CMP) && cmp_done && pass_lower;
    assign fail = (vst_ff == V_CMP) && cmp_done && !pass_lower;
    // Channel must be open and in use, and the app not blocked
    assign verify_go = cmd_verify && (vst_ff == V_IDLE) && chan_ff &&
        (sec_state_ff == `BSC_SS_CHAN) && !cur_blocked;
    assign verify_refuse = cmd_verify && !verify_go;
    // A work-sharing abort is also a security error
    assign sec_err = cmd_sec_error || fail || ws_abort_w;
    assign foreign_cmd = cmd_select || cmd_verify || cmd_chan_open;

    bsc_ws_session u_ws (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .ws_start(cmp_ws_start && (vst_ff == V_CMP)),
        .ws_get_data(cmd_get_data),
        .ws_put_result(cmd_put_result),
        .ws_reject(cmd_reject),
        .other_cmd(foreign_cmd),
        .ws_busy_ff(ws_busy_w),
        .ws_waiting_ff(ws_waiting_w),
        .ws_done_ff(ws_done_w),
        .ws_abort_ff(ws_abort_w)
    );

    // Verify sequencer: idle, comparing, paused for work-sharing
    always @* begin
        nxt_vst = vst_ff;
        case (vst_ff)
            V_IDLE: begin
                if (verify_go) begin
                    nxt_vst = V_CMP;
                end
            end
            V_CMP: begin
                if (cmd_select || cmd_sec_error) begin
                    nxt_vst = V_IDLE;
                end else if (cmp_done) begin
                    nxt_vst = V_IDLE;
                end else if (cmp_ws_start) begin
                    nxt_vst = V_WS;
                end
            end
            V_WS: begin
                if (ws_abort_w || cmd_select || cmd_sec_error) begin
                    nxt_vst = V_IDLE;
                end else if (ws_done_w) begin
                    nxt_vst = V_CMP;
                end
            end
            default: begin
                nxt_vst = V_IDLE;
            end
        endcase
    end

    // Security state, channel and selection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_state_ff <= `BSC_SS_INIT;
            chan_ff <= 1'b0;
            app_ff <= {APP_W{1'b0}};
            vst_ff <= V_IDLE;
            last_score_ff <= {SCORE_W{1'b0}};
        end else if (ce) begin
            vst_ff <= nxt_vst;
            if (cmd_select) begin
                app_ff <= cmd_app;
                sec_state_ff <= `BSC_SS_INIT;
                chan_ff <= 1'b0;
            end else if (sec_err) begin
                sec_state_ff <= `BSC_SS_INIT;
                chan_ff <= 1'b0;
            end else if (cmd_chan_close) begin
                sec_state_ff <= `BSC_SS_INIT;
                chan_ff <= 1'b0;
            end else if (grant) begin
                if (!two_th_ff || !pass_upper) begin
                    sec_state_ff <= `BSC_SS_LVL1;
                end else begin
                    sec_state_ff <= `BSC_SS_LVL2;
                end
            end else if (cmd_chan_open && sec_state_ff == `BSC_SS_INIT) begin
                sec_state_ff <= `BSC_SS_CHAN;
                chan_ff <= 1'b1;
            end
            if (vst_ff == V_CMP && cmp_done) begin
                last_score_ff <= cmp_score;
            end
        end
    end

    // Per-application thresholds and retry counters
    genvar gi;
    generate
        for (gi = 0; gi < NUM_APPS; gi = gi + 1) begin : g_app
            localparam [APP_W-1:0] APP_IDX = gi;
            wire sel;
            assign sel = (app_ff == APP_IDX);
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lower_th_ff[gi] <= `BSC_LOWER_TH_RST;
                    upper_th_ff[gi] <= `BSC_UPPER_TH_RST;
                    retry_init_ff[gi] <= `BSC_RETRY_RST;
                    retry_ff[gi] <= `BSC_RETRY_RST;
                end else if (ce) begin
                    // Software reaches only the selected app's settings
                    if (reg_wr && sel) begin
                        if (reg_addr == `BSC_REG_LOWER_TH) begin
                            lower_th_ff[gi] <= reg_wdata[SCORE_W-1:0];
                        end
                        if (reg_addr == `BSC_REG_UPPER_TH) begin
                            upper_th_ff[gi] <= reg_wdata[SCORE_W-1:0];
                        end
                        if (reg_addr == `BSC_REG_RETRY_INIT) begin
                            retry_init_ff[gi] <= reg_wdata[RETRY_W-1:0];
                            retry_ff[gi] <= reg_wdata[RETRY_W-1:0];
                        end
                    end
                    if (sel && grant) begin
                        retry_ff[gi] <= retry_init_ff[gi];
                    end else if (sel && fail && retry_ff[gi] != {RETRY_W{1'b0}}) begin
                        retry_ff[gi] <= retry_ff[gi] - 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Event pulses and status outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_start_ff <= 1'b0;
            verify_ok_ff <= 1'b0;
            verify_fail_ff <= 1'b0;
            verify_refused_ff <= 1'b0;
            app_blocked_ff <= 1'b0;
            ws_busy_ff <= 1'b0;
            ws_abort_ff <= 1'b0;
        end else if (ce) begin
            cmp_start_ff <= verify_go;
            verify_ok_ff <= grant;
            verify_fail_ff <= fail;
            verify_refused_ff <= verify_refuse;
            app_blocked_ff <= cur_blocked;
            ws_busy_ff <= ws_busy_w;
            ws_abort_ff <= ws_abort_w;
        end
    end

    // Register port: control write and one-cycle read data
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            two_th_ff <= 1'b0;
            reg_rdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            if (reg_wr && reg_addr == `BSC_REG_CTRL) begin
                two_th_ff <= reg_wdata[`BSC_CTRL_TWO_TH];
            end
            if (reg_rd) begin
                case (reg_addr)
                    `BSC_REG_CTRL: reg_rdata_ff <= {31'h0, two_th_ff};
                    `BSC_REG_STATUS: reg_rdata_ff <= {16'h0, {(8-APP_W){1'b0}}, app_ff,
                        2'b00, ws_waiting_w, ws_busy_w, cur_blocked, chan_ff,
                        sec_state_ff};
                    `BSC_REG_LOWER_TH: reg_rdata_ff <= {{(32-SCORE_W){1'b0}}, cur_lower};
                    `BSC_REG_UPPER_TH: reg_rdata_ff <= {{(32-SCORE_W){1'b0}}, cur_upper};
                    `BSC_REG_RETRY_INIT: reg_rdata_ff <=
                        {{(32-RETRY_W){1'b0}}, retry_init_ff[app_ff]};
                    `BSC_REG_RETRY: reg_rdata_ff <= {{(32-RETRY_W){1'b0}}, retry_ff[app_ff]};
                    `BSC_REG_SCORE: reg_rdata_ff <= {{(32-SCORE_W){1'b0}}, last_score_ff};
                    default: reg_rdata_ff <= 32'h0000_0000;
                endcase
            end else begin
                reg_rdata_ff <= 32'h0000_0000;
            end
        end
    end
endmodule

// *** verilog/bsc_regs.vh ***
// Purpose: constants for the biometric security-state controller
// Assumes: 40 MHz clock, register index times four is the byte address
// Notes: offsets chosen for this block; no printed map exists
`ifndef BSC_REGS_VH
`define BSC_REGS_VH
`define BSC_REG_CTRL 4'h0
`define BSC_REG_STATUS 4'h1
`define BSC_REG_LOWER_TH 4'h2
`define BSC_REG_UPPER_TH 4'h3
`define BSC_REG_RETRY_INIT 4'h4
`define BSC_REG_RETRY 4'h5
`define BSC_REG_SCORE 4'h6
`define BSC_CTRL_TWO_TH 0
`define BSC_SS_INIT 2'h0
`define BSC_SS_CHAN 2'h1
`define BSC_SS_LVL1 2'h2
`define BSC_SS_LVL2 2'h3
`define BSC_RETRY_RST 4'h3
`define BSC_LOWER_TH_RST 8'h80
`define BSC_UPPER_TH_RST 8'hc0
`define BSC_WS_TIMEOUT_US 100
`define BSC_CLK_MHZ 40
`define BSC_WS_TIMEOUT_CYC (`BSC_WS_TIMEOUT_US * `BSC_CLK_MHZ)
`endif

// *** verilog/bsc_ws_session.v ***
// Purpose: work-sharing request session sequencer
// Assumes: command strobes are one-cycle pulses from same-clock logic
// Notes: a reject, a select, verify or channel-open command, or a timeout drops the session back to ready
`timescale 1ns/1ps
`include "bsc_regs.vh"
module bsc_ws_session #(
    parameter TIMEOUT_CYC = `BSC_WS_TIMEOUT_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire ws_start,
    input wire ws_get_data,
    input wire ws_put_result,
    input wire ws_reject,
    input wire other_cmd,
    output reg ws_busy_ff,
    output reg ws_waiting_ff,
    output reg ws_done_ff,
    output reg ws_abort_ff
);
    localparam S_READY = 2'd0;
    localparam S_REQ = 2'd1;
    localparam S_WAIT_RES = 2'd2;
    localparam [15:0] TMO_LIM = TIMEOUT_CYC;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [15:0] tmo_ff;
    reg [15:0] nxt_tmo;
    reg nxt_done;
    reg nxt_abort;

    // Session steps: request out, GET DATA, result back
    always @* begin
        nxt_state = state_ff;
        nxt_tmo = tmo_ff;
        nxt_done = 1'b0;
        nxt_abort = 1'b0;
        case (state_ff)
            S_READY: begin
                nxt_tmo = 16'h0000;
                if (ws_start) begin
                    nxt_state = S_REQ;
                end
            end
            S_REQ: begin
                nxt_tmo = tmo_ff + 16'h0001;
                if (ws_reject || other_cmd || tmo_ff == TMO_LIM) begin
                    nxt_state = S_READY;
                    nxt_abort = 1'b1;
                end else if (ws_get_data) begin
                    nxt_state = S_WAIT_RES;
                    nxt_tmo = 16'h0000;
                end
            end
            S_WAIT_RES: begin
                nxt_tmo = tmo_ff + 16'h0001;
                if (ws_reject || other_cmd || tmo_ff == TMO_LIM) begin
                    nxt_state = S_READY;
                    nxt_abort = 1'b1;
                end else if (ws_put_result) begin
                    nxt_state = S_READY;
                    nxt_done = 1'b1;
                end
            end
            default: begin
                nxt_state = S_READY;
            end
        endcase
    end

    // Registered state and pulses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_READY;
            tmo_ff <= 16'h0000;
            ws_busy_ff <= 1'b0;
            ws_waiting_ff <= 1'b0;
            ws_done_ff <= 1'b0;
            ws_abort_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            tmo_ff <= nxt_tmo;
            ws_busy_ff <= (nxt_state != S_READY);
            ws_waiting_ff <= (nxt_state == S_WAIT_RES);
            ws_done_ff <= nxt_done;
            ws_abort_ff <= nxt_abort;
        end
    end
endmodule
